// [ufc_pkg.sv]
// Package for the UART flow, power and interrupt control block.
// Assumes a single 40 MHz clock domain and an 8-bit register port.
package ufc_pkg;
  // Register offsets
  localparam logic [7:0] ADDR_RX_FIFO_READ = 8'h00;
  localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h01;
  localparam logic [7:0] ADDR_IRQ_SUMMARY = 8'h02;
  localparam logic [7:0] ADDR_LINE_IRQ_EN = 8'h03;
  localparam logic [7:0] ADDR_SPCL_EVENTS = 8'h04;
  localparam logic [7:0] ADDR_SPCL_EVENT_EN = 8'h05;
  localparam logic [7:0] ADDR_STATUS_EVENTS = 8'h06;
  localparam logic [7:0] ADDR_STATUS_EVENT_EN = 8'h07;
  localparam logic [7:0] ADDR_MODE_ONE = 8'h08;
  localparam logic [7:0] ADDR_FLOW_CONFIG = 8'h09;
  localparam logic [7:0] ADDR_FLOW_LEVELS = 8'h0a;
  localparam logic [7:0] ADDR_TRIG_LEVELS = 8'h0b;
  localparam logic [7:0] ADDR_RESUME_FIRST = 8'h0c;
  localparam logic [7:0] ADDR_RESUME_SECOND = 8'h0d;
  localparam logic [7:0] ADDR_STOP_FIRST = 8'h0e;
  localparam logic [7:0] ADDR_STOP_SECOND = 8'h0f;
  localparam logic [7:0] ADDR_LINE_STATUS = 8'h10;
  localparam logic [7:0] ADDR_REVISION = 8'h11;
  // Field positions
  localparam int MODE_TX_DISABLE_BIT = 1;
  localparam int MODE_FORCE_SLEEP_BIT = 5;
  localparam int MODE_AUTOSLEEP_BIT = 6;
  localparam int MODE_IRQ_SELECT_BIT = 7;
  localparam int SUM_LINE_BIT = 0;
  localparam int SUM_SPCL_BIT = 1;
  localparam int SUM_STATUS_BIT = 2;
  localparam int SUM_RX_TRIG_BIT = 3;
  localparam int SUM_TX_TRIG_BIT = 4;
  localparam int SUM_TX_EMPTY_BIT = 5;
  localparam int SUM_RX_EMPTY_BIT = 6;
  localparam int STS_CLOCK_READY_BIT = 5;
  localparam int SPCL_RESUME_BIT = 0;
  localparam int SPCL_STOP_BIT = 1;
  // Reset values
  localparam logic [7:0] SUMMARY_RESET = 8'h60;
  localparam logic [7:0] REVISION_VALUE = 8'ha5; // Arbitrary value
  // Timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int INIT_DELAY_NS = 1000;
  localparam int INIT_DELAY_CYC = (INIT_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CLOCK_STABLE_NS = 500;
  localparam int CLOCK_STABLE_CYC = (CLOCK_STABLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int IDLE_CHARS = 65536;

  typedef enum logic [1:0]
  {
    TXS_IDLE = 2'b00,
    TXS_FIRST = 2'b01,
    TXS_SECOND = 2'b10
  } ufc_flow_tx_t;

  typedef struct packed
  {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } ufc_reg_req_t;
endpackage : ufc_pkg

// [ufc_fifo.sv]
// Small synchronous FIFO with valid/ready on both sides.
// Assumes one clock; full and empty are exact.
`timescale 1ns/1ps
module ufc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  // Fill side
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  // Drain side
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out,
  // Fill level
  output logic [$clog2(DEPTH+1)-1:0] count_out
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wp_reg;
  logic [AW-1:0] rp_reg;
  logic [$clog2(DEPTH+1)-1:0] cnt_reg;
  wire push = in_valid_in && in_ready_out;
  wire pop = out_valid_out && out_ready_in;

  assign in_ready_out = (cnt_reg != DEPTH[$clog2(DEPTH+1)-1:0]);
  assign out_valid_out = (cnt_reg != '0);
  assign out_data_out = mem_reg[rp_reg];
  assign count_out = cnt_reg;

  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      wp_reg <= '0;
      rp_reg <= '0;
      cnt_reg <= '0;
    end
    else
    begin
      if (push)
        wp_reg <= (wp_reg == AW'(DEPTH - 1)) ? '0 : wp_reg + 1'b1;
      if (pop)
        rp_reg <= (rp_reg == AW'(DEPTH - 1)) ? '0 : rp_reg + 1'b1;
      if (push && !pop)
        cnt_reg <= cnt_reg + 1'b1;
      else if (pop && !push)
        cnt_reg <= cnt_reg - 1'b1;
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (push)
      mem_reg[wp_reg] <= in_data_in;
  end
endmodule : ufc_fifo

// [ufc_ctrl.sv]
// UART flow control, power modes and interrupt structure.
// Assumes a character-level receiver/transmitter outside; registers on an 8-bit port.
`timescale 1ns/1ps
module ufc_ctrl
  import ufc_pkg::*;
#(
  parameter int FIFO_DEPTH = 4,
  parameter int CHAR_CYCLES = 400,
  parameter int IDLE_CYCLES = 26214400
) (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic reset_in,
  // Register port
  input wire ufc_reg_req_t reg_req_in,
  output logic [7:0] reg_rdata_out,
  // Receiver character stream
  input wire logic rx_valid_in,
  input wire logic [7:0] rx_data_in,
  input wire logic [5:0] line_status_in,
  // Transmitter interface
  input wire logic tx_busy_in,
  input wire logic [$clog2(FIFO_DEPTH+1)-1:0] tx_level_in,
  output logic tx_halt_out,
  output logic flow_valid_out,
  output logic [7:0] flow_data_out,
  input wire logic flow_ready_in,
  // Input pins watched for activity
  input wire logic [3:0] gpio_in,
  input wire logic rx_pin_in,
  input wire logic cts_pin_in,
  // Power and interrupt
  output logic clocks_run_out,
  output logic irq_n_out
);
  localparam int CW = $clog2(FIFO_DEPTH+1);

  // Registers
  logic [7:0] irq_en_reg, line_en_reg, spcl_en_reg, sts_en_reg, mode_reg;
  logic [7:0] flow_cfg_reg, levels_reg, trig_reg;
  logic [7:0] res1_reg, res2_reg, stop1_reg, stop2_reg;
  logic [7:0] summary_reg, spcl_reg, sts_reg, rdata_reg;
  logic [7:0] summary_next, spcl_next, sts_next;
  logic halted_reg, rx_stop_sent_reg, ready_reg, asleep_reg, irq_n_reg;
  logic wait_second_reg, clocks_run_reg;
  logic [15:0] init_cnt_reg;
  logic [15:0] stable_cnt_reg;
  logic [31:0] idle_cnt_reg;
  logic [5:0] pins_prev_reg;
  logic [7:0] first_char_reg;
  ufc_flow_tx_t ftx_reg;
  logic send_stop_reg;

  // Decode
  wire wr = reg_req_in.wr;
  wire rd = reg_req_in.rd;
  wire [7:0] a = reg_req_in.addr;
  wire rd_summary = rd && (a == ADDR_IRQ_SUMMARY);
  wire rd_spcl = rd && (a == ADDR_SPCL_EVENTS);
  wire rd_sts = rd && (a == ADDR_STATUS_EVENTS);
  wire rd_fifo = rd && (a == ADDR_RX_FIFO_READ);
  wire sleeping = mode_reg[MODE_FORCE_SLEEP_BIT] || asleep_reg;

  // Flow configuration fields
  wire tx_flow_on = |flow_cfg_reg[5:4];
  wire rx_flow_on = |flow_cfg_reg[7:6];
  wire dual = flow_cfg_reg[3];
  wire [3:0] halt_lvl = levels_reg[3:0];
  wire [3:0] resume_lvl = levels_reg[7:4];

  // Character matching
  wire rx_ok = rx_valid_in && !sleeping;
  wire m_stop1 = (rx_data_in == stop1_reg);
  wire m_res1 = (rx_data_in == res1_reg);
  wire m_stop2 = wait_second_reg && (rx_data_in == stop2_reg) && (first_char_reg == stop1_reg);
  wire m_res2 = wait_second_reg && (rx_data_in == res2_reg) && (first_char_reg == res1_reg);
  wire got_stop = tx_flow_on && rx_ok && (dual ? m_stop2 : m_stop1);
  wire got_res = tx_flow_on && rx_ok && (dual ? m_res2 : m_res1);
  // A held first byte is dropped even if no pair follows; limitation of pair matching
  wire first_hold = tx_flow_on && dual && rx_ok && (m_stop1 || m_res1);
  wire drop = got_stop || got_res || first_hold;

  // Receive FIFO
  logic rx_fifo_vld;
  logic [7:0] rx_fifo_data;
  logic [CW-1:0] rx_count;
  ufc_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) rx_fifo (
    .clk_in(mclk_in),
    .reset_in(reset_in),
    .in_valid_in(rx_ok && !drop),
    .in_ready_out(),
    .in_data_in(rx_data_in),
    .out_valid_out(rx_fifo_vld),
    .out_ready_in(rd_fifo),
    .out_data_out(rx_fifo_data),
    .count_out(rx_count)
  );

  // Levels
  wire [4:0] rxc = 5'(rx_count);
  wire [4:0] txc = 5'(tx_level_in);
  wire rx_trig = (trig_reg[7:4] != 4'h0) && (rxc >= {1'b0, trig_reg[7:4]});
  wire tx_trig = (trig_reg[3:0] != 4'h0) && (txc >= {1'b0, trig_reg[3:0]});
  wire need_stop = rx_flow_on && !rx_stop_sent_reg && (rxc >= {1'b0, halt_lvl});
  wire need_res = rx_flow_on && rx_stop_sent_reg && (rxc <= {1'b0, resume_lvl});

  // Sender outputs follow the next state, so valid and data change together
  wire flow_take = flow_valid_out && flow_ready_in;
  wire flow_start = need_stop || need_res;
  wire stop_next = (ftx_reg == TXS_IDLE) ? need_stop : send_stop_reg;
  ufc_flow_tx_t ftx_next;
  assign ftx_next = (ftx_reg == TXS_IDLE) ? (flow_start ? TXS_FIRST : TXS_IDLE)
                    : !flow_take ? ftx_reg
                    : (ftx_reg == TXS_FIRST && dual) ? TXS_SECOND : TXS_IDLE;

  // Interrupt aggregation
  wire line_any = |(line_status_in & line_en_reg[5:0]);
  wire sts_any = |(sts_reg & sts_en_reg);
  wire spcl_any = |(spcl_reg & spcl_en_reg);
  wire irq_pending = |(summary_reg & irq_en_reg);
  wire pins_moved = ({gpio_in, rx_pin_in, cts_pin_in} != pins_prev_reg);
  wire fifos_empty = !rx_fifo_vld && (tx_level_in == '0);

  always_comb
  begin
    sts_next = rd_sts ? 8'h00 : sts_reg;
    if (stable_cnt_reg == 16'(CLOCK_STABLE_CYC))
      sts_next[STS_CLOCK_READY_BIT] = 1'b1;
    spcl_next = rd_spcl ? 8'h00 : spcl_reg;
    if (got_res)
      spcl_next[SPCL_RESUME_BIT] = 1'b1;
    if (got_stop)
      spcl_next[SPCL_STOP_BIT] = 1'b1;
    summary_next = rd_summary ? 8'h00 : summary_reg;
    summary_next[SUM_LINE_BIT] = summary_next[SUM_LINE_BIT] | line_any;
    summary_next[SUM_SPCL_BIT] = summary_next[SUM_SPCL_BIT] | got_stop | got_res;
    summary_next[SUM_STATUS_BIT] = summary_next[SUM_STATUS_BIT] | sts_any;
    summary_next[SUM_RX_TRIG_BIT] = summary_next[SUM_RX_TRIG_BIT] | rx_trig;
    summary_next[SUM_TX_TRIG_BIT] = (summary_next[SUM_TX_TRIG_BIT] | tx_trig) & tx_trig;
    summary_next[SUM_TX_EMPTY_BIT] = summary_next[SUM_TX_EMPTY_BIT] | (tx_level_in == '0);
    summary_next[SUM_RX_EMPTY_BIT] = summary_next[SUM_RX_EMPTY_BIT] | !rx_fifo_vld;
  end

  // Read data mux
  logic [7:0] rmux;
  always_comb
  begin
    unique case (a)
      ADDR_RX_FIFO_READ: rmux = rx_fifo_data;
      ADDR_IRQ_ENABLE: rmux = irq_en_reg;
      ADDR_IRQ_SUMMARY: rmux = summary_reg;
      ADDR_LINE_IRQ_EN: rmux = line_en_reg;
      ADDR_SPCL_EVENTS: rmux = spcl_reg;
      ADDR_SPCL_EVENT_EN: rmux = spcl_en_reg;
      ADDR_STATUS_EVENTS: rmux = sts_reg;
      ADDR_STATUS_EVENT_EN: rmux = sts_en_reg;
      ADDR_MODE_ONE: rmux = mode_reg;
      ADDR_FLOW_CONFIG: rmux = flow_cfg_reg;
      ADDR_FLOW_LEVELS: rmux = levels_reg;
      ADDR_TRIG_LEVELS: rmux = trig_reg;
      ADDR_RESUME_FIRST: rmux = res1_reg;
      ADDR_RESUME_SECOND: rmux = res2_reg;
      ADDR_STOP_FIRST: rmux = stop1_reg;
      ADDR_STOP_SECOND: rmux = stop2_reg;
      ADDR_LINE_STATUS: rmux = {2'b00, line_status_in};
      ADDR_REVISION: rmux = ready_reg ? REVISION_VALUE : 8'h00;
      default: rmux = 8'h00;
    endcase
  end

  // Register writes; reset acts as shutdown and clears everything
  always_ff @(posedge mclk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      irq_en_reg <= 8'h00;
      line_en_reg <= 8'h00;
      spcl_en_reg <= 8'h00;
      sts_en_reg <= 8'h00;
      mode_reg <= 8'h00;
      flow_cfg_reg <= 8'h00;
      levels_reg <= 8'h00;
      trig_reg <= 8'h00;
      res1_reg <= 8'h00;
      res2_reg <= 8'h00;
      stop1_reg <= 8'h00;
      stop2_reg <= 8'h00;
    end
    else if (wr)
    begin
      unique case (a)
        ADDR_IRQ_ENABLE: irq_en_reg <= reg_req_in.wdata;
        ADDR_LINE_IRQ_EN: line_en_reg <= reg_req_in.wdata;
        ADDR_SPCL_EVENT_EN: spcl_en_reg <= reg_req_in.wdata;
        ADDR_STATUS_EVENT_EN: sts_en_reg <= reg_req_in.wdata;
        ADDR_MODE_ONE: mode_reg <= reg_req_in.wdata;
        ADDR_FLOW_CONFIG: flow_cfg_reg <= reg_req_in.wdata;
        ADDR_FLOW_LEVELS: levels_reg <= reg_req_in.wdata;
        ADDR_TRIG_LEVELS: trig_reg <= reg_req_in.wdata;
        ADDR_RESUME_FIRST: res1_reg <= reg_req_in.wdata;
        ADDR_RESUME_SECOND: res2_reg <= reg_req_in.wdata;
        ADDR_STOP_FIRST: stop1_reg <= reg_req_in.wdata;
        ADDR_STOP_SECOND: stop2_reg <= reg_req_in.wdata;
        default: ;
      endcase
    end
  end

  // Event registers and read data
  always_ff @(posedge mclk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      summary_reg <= SUMMARY_RESET;
      spcl_reg <= 8'h00;
      sts_reg <= 8'h00;
      rdata_reg <= 8'h00;
    end
    else
    begin
      summary_reg <= summary_next;
      spcl_reg <= spcl_next;
      sts_reg <= sts_next;
      if (rd)
        rdata_reg <= rmux;
    end
  end

  // Transmit halt from received characters; pair tracking
  always_ff @(posedge mclk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      halted_reg <= 1'b0;
      wait_second_reg <= 1'b0;
      first_char_reg <= 8'h00;
    end
    else
    begin
      if (!tx_flow_on)
        halted_reg <= 1'b0;
      else if (got_stop)
        halted_reg <= 1'b1;
      else if (got_res)
        halted_reg <= 1'b0;
      if (rx_ok)
      begin
        wait_second_reg <= first_hold && !wait_second_reg;
        first_char_reg <= rx_data_in;
      end
    end
  end

  // Automatic stop/resume sender
  always_ff @(posedge mclk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      ftx_reg <= TXS_IDLE;
      rx_stop_sent_reg <= 1'b0;
      send_stop_reg <= 1'b0;
    end
    else
    begin
      unique case (ftx_reg)
        TXS_IDLE:
          if (need_stop || need_res)
          begin
            send_stop_reg <= need_stop;
            rx_stop_sent_reg <= need_stop;
            ftx_reg <= TXS_FIRST;
          end
        TXS_FIRST:
          if (flow_take)
            ftx_reg <= dual ? TXS_SECOND : TXS_IDLE;
        TXS_SECOND:
          if (flow_take)
            ftx_reg <= TXS_IDLE;
        default: ftx_reg <= TXS_IDLE;
      endcase
      if (!rx_flow_on)
        rx_stop_sent_reg <= 1'b0;
    end
  end

  // Sleep, wake, initialization and interrupt pin
  always_ff @(posedge mclk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      asleep_reg <= 1'b0;
      idle_cnt_reg <= '0;
      pins_prev_reg <= '0;
      stable_cnt_reg <= '0;
      init_cnt_reg <= '0;
      ready_reg <= 1'b0;
      irq_n_reg <= 1'b0;
      clocks_run_reg <= 1'b0;
    end
    else
    begin
      pins_prev_reg <= {gpio_in, rx_pin_in, cts_pin_in};
      if (!mode_reg[MODE_AUTOSLEEP_BIT] || pins_moved || !fifos_empty || irq_pending)
        idle_cnt_reg <= '0;
      else if (idle_cnt_reg != 32'(IDLE_CYCLES))
        idle_cnt_reg <= idle_cnt_reg + 32'd1;
      if (!mode_reg[MODE_AUTOSLEEP_BIT] || pins_moved)
        asleep_reg <= 1'b0;
      else if (idle_cnt_reg == 32'(IDLE_CYCLES))
        asleep_reg <= 1'b1;
      clocks_run_reg <= ready_reg && !sleeping;
      // Counts only while clocks run, so each wake restarts the settle time
      if (sleeping || !ready_reg)
        stable_cnt_reg <= '0;
      else if (stable_cnt_reg <= 16'(CLOCK_STABLE_CYC))
        stable_cnt_reg <= stable_cnt_reg + 16'd1;
      if (init_cnt_reg != 16'(INIT_DELAY_CYC))
        init_cnt_reg <= init_cnt_reg + 16'd1;
      else
        ready_reg <= 1'b1;
      if (!ready_reg)
        irq_n_reg <= 1'b0;
      else if (!mode_reg[MODE_IRQ_SELECT_BIT])
        irq_n_reg <= 1'b1;
      else
        irq_n_reg <= !(|(summary_next & irq_en_reg));
    end
  end

  // Outputs
  always_ff @(posedge mclk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      tx_halt_out <= 1'b1;
      flow_valid_out <= 1'b0;
      flow_data_out <= 8'h00;
    end
    else
    begin
      tx_halt_out <= halted_reg || sleeping || mode_reg[MODE_TX_DISABLE_BIT];
      flow_valid_out <= (ftx_next != TXS_IDLE);
      flow_data_out <= (ftx_next == TXS_SECOND) ? (stop_next ? stop2_reg : res2_reg)
                       : (stop_next ? stop1_reg : res1_reg);
    end
  end

  assign reg_rdata_out = rdata_reg;
  assign irq_n_out = irq_n_reg;
  assign clocks_run_out = clocks_run_reg;
endmodule : ufc_ctrl

// [ufc_ctrl_checker.sv]
// Concurrent checks on the ports of the flow, power and interrupt block.
// Assumes binding onto ufc_ctrl; register writes are mirrored for context.
`timescale 1ns/1ps
module ufc_ctrl_checker
  import ufc_pkg::*;
(
  input wire logic mclk_in,
  input wire logic reset_in,
  input wire ufc_reg_req_t reg_req_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic rx_valid_in,
  input wire logic [7:0] rx_data_in,
  input wire logic [3:0] gpio_in,
  input wire logic tx_halt_out,
  input wire logic flow_valid_out,
  input wire logic [7:0] flow_data_out,
  input wire logic flow_ready_in,
  input wire logic clocks_run_out,
  input wire logic irq_n_out
);
  logic [7:0] shadow_reg [0:17];
  wire logic [7:0] mode_w = shadow_reg[8];
  wire logic [7:0] flow_w = shadow_reg[9];
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (reset_in);
  // Mirror only; a write to an unmapped place is not stored
  always_ff @(posedge mclk_in or posedge reset_in)
    if (reset_in)
      for (int k = 0; k < 18; k++) shadow_reg[k] <= 8'h00;
    else if (reg_req_in.wr && reg_req_in.addr < 8'h12)
      shadow_reg[reg_req_in.addr[4:0]] <= reg_req_in.wdata;
  property p_init_low;
    $fell(reset_in) |-> (!irq_n_out) [*8];
  endproperty
  a_init_low: assert property (p_init_low) else $error("pin rose too early after reset");
  property p_init_high;
    $fell(reset_in) |-> ##[1:80] irq_n_out;
  endproperty
  a_init_high: assert property (p_init_high) else $error("pin never went high");
  property p_flow_hold;
    flow_valid_out && !flow_ready_in |=> flow_valid_out && $stable(flow_data_out);
  endproperty
  a_flow_hold: assert property (p_flow_hold) else $error("flow char dropped early");
  property p_sleep_enter;
    $rose(mode_w[5]) |-> ##[0:3] (!clocks_run_out && tx_halt_out);
  endproperty
  a_sleep_enter: assert property (p_sleep_enter) else $error("forced sleep missed");
  property p_sleep_exit;
    $fell(mode_w[5]) && !mode_w[6] |-> ##[1:6] clocks_run_out;
  endproperty
  a_sleep_exit: assert property (p_sleep_exit) else $error("wake missed");
  property p_wake;
    mode_w[6] && !mode_w[5] && !clocks_run_out && $changed(gpio_in) |-> ##[1:4] clocks_run_out;
  endproperty
  a_wake: assert property (p_wake) else $error("autosleep did not wake");
  property p_stop_halt;
    rx_valid_in && rx_data_in == shadow_reg[14] && flow_w[5:4] != 2'b00 && !flow_w[3]
      && clocks_run_out |-> ##[1:3] tx_halt_out;
  endproperty
  a_stop_halt: assert property (p_stop_halt) else $error("stop char did not halt");
  property p_rev_ready;
    reg_req_in.rd && reg_req_in.addr == ADDR_REVISION && irq_n_out
      |=> reg_rdata_out == REVISION_VALUE;
  endproperty
  a_rev_ready: assert property (p_rev_ready) else $error("revision wrong when ready");
  property p_sum_clear;
    reg_req_in.rd && reg_req_in.addr == ADDR_IRQ_SUMMARY && mode_w[7] && !irq_n_out
      |-> ##[1:3] irq_n_out;
  endproperty
  a_sum_clear: assert property (p_sum_clear) else $error("summary read kept pin low");
  c_flow: cover property (flow_valid_out && flow_ready_in);
  c_sleep: cover property ($fell(clocks_run_out));
  c_irq: cover property ($fell(irq_n_out) && mode_w[7]);
endmodule : ufc_ctrl_checker

// [ufc_far_end.sv]
// Far-end station: takes flow chars off the valid/ready stream.
// Assumes one clock; slow mode stalls every other cycle.
`timescale 1ns/1ps
module ufc_far_end (
  // Clock and pacing
  input wire logic clk_in,
  input wire logic slow_in,
  // Flow char stream
  input wire logic flow_valid_in,
  input wire logic [7:0] flow_data_in,
  output logic flow_ready_out
);
  logic [7:0] got [$];
  initial flow_ready_out = 1'b1;
  // Order kept as taken, so paired chars show their sequence
  always @(posedge clk_in)
    if (flow_valid_in && flow_ready_out) got.push_back(flow_data_in);
  always @(negedge clk_in) flow_ready_out <= slow_in ? ~flow_ready_out : 1'b1;
endmodule : ufc_far_end

// [tb_top.sv]
// Bench for the flow, power and interrupt block with a far-end model.
// Assumes package, checker and far-end model are compiled first.
`timescale 1ns/1ps
module tb_top;
  import ufc_pkg::*;
  logic mclk_in = 1'b0;
  logic reset_in = 1'b1;
  ufc_reg_req_t req = '0;
  logic rx_valid = 1'b0;
  logic [7:0] rx_data = 8'h00;
  logic [2:0] tx_level = 3'h0;
  logic [3:0] gpio = 4'h0;
  logic slow = 1'b0;
  logic [5:0] line_sts = 6'h00;
  logic rx_pin = 1'b1;
  logic cts_pin = 1'b1;
  logic [7:0] rdata, fdata, v;
  logic tx_halt, fvalid, fready, clk_run, irq_n;
  int err_total = 0;
  int samples_checked = 0;
  int cyc = 0;
  int i;
  // Char in, char expected out
  logic [15:0] rows [0:3] = '{16'h4141, 16'h0000, 16'hffff, 16'h5a5a};
  always #12.5 mclk_in = ~mclk_in;
  ufc_ctrl #(.FIFO_DEPTH(4), .CHAR_CYCLES(4), .IDLE_CYCLES(50)) dut (
    .mclk_in(mclk_in), .reset_in(reset_in), .reg_req_in(req), .reg_rdata_out(rdata),
    .rx_valid_in(rx_valid), .rx_data_in(rx_data), .line_status_in(line_sts),
    .tx_busy_in(1'b0), .tx_level_in(tx_level), .tx_halt_out(tx_halt),
    .flow_valid_out(fvalid), .flow_data_out(fdata), .flow_ready_in(fready),
    .gpio_in(gpio), .rx_pin_in(rx_pin), .cts_pin_in(cts_pin),
    .clocks_run_out(clk_run), .irq_n_out(irq_n));
  ufc_far_end pe (.clk_in(mclk_in), .slow_in(slow), .flow_valid_in(fvalid),
    .flow_data_in(fdata), .flow_ready_out(fready));
  task final_report;
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : final_report
  task check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk_in) req = '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(negedge mclk_in) req = '0;
  endtask : wr
  task rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge mclk_in) req = '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(negedge mclk_in) req = '0;
    @(negedge mclk_in) d = rdata;
  endtask : rd
  // Idle data line shows the inverse so a stale value never matches
  task rx(input logic [7:0] c);
    @(negedge mclk_in) {rx_valid, rx_data} = {1'b1, c};
    @(negedge mclk_in) {rx_valid, rx_data} = {1'b0, ~c};
  endtask : rx
  task wait_irq_high;
    for (i = 0; i < 100 && irq_n !== 1'b1; i++) @(negedge mclk_in);
  endtask : wait_irq_high
  always @(posedge mclk_in)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_total++;
      final_report();
    end
  end
  initial
  begin
    repeat (8) @(negedge mclk_in);
    check("irq in reset", {7'h0, irq_n}, 8'h00);
    check("halt in reset", {7'h0, tx_halt}, 8'h01);
    reset_in = 1'b0;
    rd(ADDR_REVISION, v);
    check("early revision", v, 8'h00);
    check("irq init", {7'h0, irq_n}, 8'h00);
    wait_irq_high();
    check("irq ready", {7'h0, irq_n}, 8'h01);
    rd(ADDR_REVISION, v);
    check("revision", v, REVISION_VALUE);
    $display("test reset done");
    // Fifth char meets a full FIFO and is lost
    for (int r = 0; r < 4; r++) rx(rows[r][15:8]);
    rx(8'h77);
    for (int r = 0; r < 4; r++)
    begin
      rd(ADDR_RX_FIFO_READ, v);
      check("rx pop", v, rows[r][7:0]);
    end
    rx(8'h33);
    rd(ADDR_RX_FIFO_READ, v);
    check("after full", v, 8'h33);
    $display("test fifo done");
    wr(ADDR_TRIG_LEVELS, 8'h23);
    tx_level = 3'h3;
    rx(8'h01);
    rx(8'h02);
    rd(ADDR_IRQ_SUMMARY, v);
    check("triggers", {6'h0, v[4:3]}, 8'h03);
    rd(ADDR_RX_FIFO_READ, v);
    rd(ADDR_RX_FIFO_READ, v);
    tx_level = 3'h0;
    wr(ADDR_TRIG_LEVELS, 8'h00);
    $display("test trigger done");
    // Line status bit stays while its cause stays
    wr(ADDR_LINE_IRQ_EN, 8'h01);
    line_sts = 6'h01;
    rd(ADDR_IRQ_SUMMARY, v);
    check("line int", {7'h0, v[SUM_LINE_BIT]}, 8'h01);
    rd(ADDR_LINE_STATUS, v);
    check("line held", v, 8'h01);
    line_sts = 6'h00;
    rd(ADDR_IRQ_SUMMARY, v);
    rd(ADDR_IRQ_SUMMARY, v);
    check("line gone", {7'h0, v[SUM_LINE_BIT]}, 8'h00);
    wr(ADDR_LINE_IRQ_EN, 8'h00);
    $display("test line done");
    wr(ADDR_MODE_ONE, 8'h02);
    wr(ADDR_FLOW_CONFIG, 8'h30);
    wr(ADDR_STOP_FIRST, 8'h13);
    wr(ADDR_RESUME_FIRST, 8'h11);
    wr(ADDR_SPCL_EVENT_EN, 8'h03);
    wr(ADDR_IRQ_ENABLE, 8'h02);
    wr(ADDR_MODE_ONE, 8'h80);
    rd(ADDR_IRQ_SUMMARY, v);
    rd(ADDR_SPCL_EVENTS, v);
    rx(8'h13);
    repeat (3) @(negedge mclk_in);
    check("stop halts", {7'h0, tx_halt}, 8'h01);
    check("irq pending", {7'h0, irq_n}, 8'h00);
    rd(ADDR_IRQ_SUMMARY, v);
    check("summary bit1", {7'h0, v[1]}, 8'h01);
    @(negedge mclk_in);
    check("irq cleared", {7'h0, irq_n}, 8'h01);
    rd(ADDR_SPCL_EVENTS, v);
    check("stop event", {6'h0, v[1:0]}, 8'h02);
    rd(ADDR_SPCL_EVENTS, v);
    check("events clear", v, 8'h00);
    rx(8'h5a);
    rx(8'h11);
    repeat (3) @(negedge mclk_in);
    check("resume runs", {7'h0, tx_halt}, 8'h00);
    rd(ADDR_RX_FIFO_READ, v);
    check("flow chars dropped", v, 8'h5a);
    wr(ADDR_IRQ_ENABLE, 8'h00);
    $display("test tx flow done");
    // Dual chars, halt at 3, resume at 1, far end stalling
    wr(ADDR_STOP_SECOND, 8'h93);
    wr(ADDR_RESUME_SECOND, 8'h91);
    wr(ADDR_FLOW_LEVELS, 8'h13);
    wr(ADDR_FLOW_CONFIG, 8'hc8);
    slow = 1'b1;
    rx(8'h01);
    rx(8'h02);
    repeat (10) @(negedge mclk_in);
    check("no early stop", 8'(pe.got.size()), 8'h00);
    rx(8'h03);
    for (i = 0; i < 40 && pe.got.size() < 2; i++) @(negedge mclk_in);
    check("stop first", pe.got[0], 8'h13);
    check("stop second", pe.got[1], 8'h93);
    rd(ADDR_RX_FIFO_READ, v);
    rd(ADDR_RX_FIFO_READ, v);
    for (i = 0; i < 40 && pe.got.size() < 4; i++) @(negedge mclk_in);
    check("resume first", pe.got[2], 8'h11);
    check("resume second", pe.got[3], 8'h91);
    rd(ADDR_RX_FIFO_READ, v);
    wr(ADDR_FLOW_CONFIG, 8'h00);
    slow = 1'b0;
    $display("test rx flow done");
    rd(ADDR_STATUS_EVENTS, v);
    wr(ADDR_MODE_ONE, 8'ha0);
    repeat (4) @(negedge mclk_in);
    check("sleep clocks", {7'h0, clk_run}, 8'h00);
    check("sleep halt", {7'h0, tx_halt}, 8'h01);
    rd(ADDR_REVISION, v);
    check("regs in sleep", v, REVISION_VALUE);
    wr(ADDR_MODE_ONE, 8'h80);
    repeat (CLOCK_STABLE_CYC + 10) @(negedge mclk_in);
    check("woken", {7'h0, clk_run}, 8'h01);
    rd(ADDR_STATUS_EVENTS, v);
    check("clock ready", {7'h0, v[STS_CLOCK_READY_BIT]}, 8'h01);
    rd(ADDR_IRQ_SUMMARY, v);
    wr(ADDR_MODE_ONE, 8'hc0);
    for (i = 0; i < 200 && clk_run !== 1'b0; i++) @(negedge mclk_in);
    check("autosleep", {7'h0, clk_run}, 8'h00);
    gpio = 4'h1;
    repeat (4) @(negedge mclk_in);
    check("gpio wakes", {7'h0, clk_run}, 8'h01);
    for (i = 0; i < 200 && clk_run !== 1'b0; i++) @(negedge mclk_in);
    check("autosleep again", {7'h0, clk_run}, 8'h00);
    cts_pin = 1'b0;
    repeat (4) @(negedge mclk_in);
    check("cts wakes", {7'h0, clk_run}, 8'h01);
    $display("test power done");
    reset_in = 1'b1;
    @(negedge mclk_in);
    check("irq mid reset", {7'h0, irq_n}, 8'h00);
    reset_in = 1'b0;
    wait_irq_high();
    rd(ADDR_IRQ_SUMMARY, v);
    check("summary reset", v, SUMMARY_RESET);
    $display("test second reset done");
    final_report();
  end
endmodule : tb_top
bind ufc_ctrl ufc_ctrl_checker u_chk (.mclk_in(mclk_in), .reset_in(reset_in),
  .reg_req_in(reg_req_in), .reg_rdata_out(reg_rdata_out), .rx_valid_in(rx_valid_in),
  .rx_data_in(rx_data_in), .gpio_in(gpio_in), .tx_halt_out(tx_halt_out),
  .flow_valid_out(flow_valid_out), .flow_data_out(flow_data_out),
  .flow_ready_in(flow_ready_in), .clocks_run_out(clocks_run_out), .irq_n_out(irq_n_out));
